// ===== pkg/sfm_map.vh
// Overview of operation
// - Register shift amount uses low six bits; useful range zero to forty.
// - Immediate shift amount ranges zero to thirty-one only.
// - Left shift by register amount 40 to 63 acts as shift by forty.
// - Right shifts by register amount 40 to 63 act as shift by forty.
// - Arithmetic right shift fills vacated bits with the sign bit.
// - Logical right shift fills vacated bits with zeros.
// - Shifts read and write in first execute stage, zero delay slots.
// - Left shift opcodes: 110011 signed 32-bit, 010011 unsigned to 40-bit.
// - Arithmetic right opcodes: 110111 by register, 110110 by immediate.
// - Logical right opcodes: 100111 by register, 100110 by immediate.
// - Multiply forms signed product of 16-bit halves, 32-bit result.
// - Multiply halves: 11010 LL, 01010 HL, 10010 LH, 00010 HH.
// - Product is shifted left by one before delivery.
// - Shifted product 0x80000000 is replaced by 0x7FFFFFFF.
// - Saturation sets sticky flag one cycle after destination write.
`ifndef SFM_MAP_VH
`define SFM_MAP_VH

// ****************************************
// Shift opcodes
// ****************************************
`define SFM_OP_ASL_S32_REG 6'h33
`define SFM_OP_ASL_S32_IMM 6'h32
`define SFM_OP_ASL_S40_REG 6'h31
`define SFM_OP_ASL_S40_IMM 6'h30
`define SFM_OP_ASL_U40_REG 6'h13
`define SFM_OP_ASL_U40_IMM 6'h12
`define SFM_OP_ASR_S32_REG 6'h37
`define SFM_OP_ASR_S32_IMM 6'h36
`define SFM_OP_ASR_S40_REG 6'h35
`define SFM_OP_ASR_S40_IMM 6'h34
`define SFM_OP_LSR_U32_REG 6'h27
`define SFM_OP_LSR_U32_IMM 6'h26
`define SFM_OP_LSR_U40_REG 6'h25
`define SFM_OP_LSR_U40_IMM 6'h24

// ****************************************
// Multiply opcodes
// ****************************************
`define SFM_OP_MPY_LL 5'h1a
`define SFM_OP_MPY_HL 5'h0a
`define SFM_OP_MPY_LH 5'h12
`define SFM_OP_MPY_HH 5'h02

// ****************************************
// Shift amounts and saturation values
// ****************************************
`define SFM_REG_AMT_BITS 6
`define SFM_IMM_AMT_BITS 5
`define SFM_MAX_SHIFT 6'h28
`define SFM_MOST_NEG 32'h8000_0000
`define SFM_MAX_POS 32'h7fff_ffff

`endif

// ===== hdl/sfm_frac_mult.v
`timescale 1ns/10ps
`default_nettype none
`include "sfm_map.vh"

module sfm_frac_mult (
	input wire ref_clk,
	input wire sys_rst,
	input wire mul_valid,
	input wire mul_pred,
	input wire [4:0] mul_opcode,
	input wire [31:0] mul_src1,
	input wire [31:0] mul_src2,
	output reg mul_wr_reg,
	output reg [31:0] mul_result_reg,
	output reg mul_sat_reg
);

	reg [15:0] half_a;
	reg [15:0] half_b;
	reg legal_op;
	wire signed [31:0] prod;
	wire [31:0] shifted;
	wire saturate;

	// ****************************************
	// Half selection
	// ****************************************
	always @* begin
		half_a = mul_src1[15:0];
		half_b = mul_src2[15:0];
		legal_op = 1'b1;
		case (mul_opcode)
		`SFM_OP_MPY_LL: begin
			half_a = mul_src1[15:0];
			half_b = mul_src2[15:0];
		end
		`SFM_OP_MPY_HL: begin
			half_a = mul_src1[31:16];
			half_b = mul_src2[15:0];
		end
		`SFM_OP_MPY_LH: begin
			half_a = mul_src1[15:0];
			half_b = mul_src2[31:16];
		end
		`SFM_OP_MPY_HH: begin
			half_a = mul_src1[31:16];
			half_b = mul_src2[31:16];
		end
		default: begin
			legal_op = 1'b0;
		end
		endcase
	end

	assign prod = $signed(half_a) * $signed(half_b);
	assign shifted = {prod[30:0], 1'b0};
	assign saturate = (shifted == `SFM_MOST_NEG);

	// ****************************************
	// Second stage write and late flag
	// ****************************************
	// Result lands one cycle after issue; flag one cycle after that
	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mul_wr_reg <= 1'b0;
			mul_result_reg <= 32'h0000_0000;
			mul_sat_reg <= 1'b0;
		end else begin
			mul_wr_reg <= mul_valid && mul_pred && legal_op;
			// Raised with the write; the sticky flag follows a cycle later
			mul_sat_reg <= mul_valid && mul_pred && legal_op && saturate;
			if (mul_valid && mul_pred && legal_op) begin
				if (saturate) begin
					mul_result_reg <= `SFM_MAX_POS;
				end else begin
					mul_result_reg <= shifted;
				end
			end
		end
	end

endmodule
`default_nettype wire

// ===== hdl/sfm_unit.v
`timescale 1ns/10ps
`default_nettype none
`include "sfm_map.vh"

module sfm_unit (
	input wire ref_clk,
	input wire sys_rst,
	input wire shf_valid,
	input wire shf_pred,
	input wire [5:0] shf_opcode,
	input wire [39:0] shf_src2,
	input wire [31:0] shf_src1,
	input wire [4:0] shf_imm,
	output reg shf_wr,
	output reg [39:0] shf_result,
	output reg shf_wide,
	input wire mul_valid,
	input wire mul_pred,
	input wire [4:0] mul_opcode,
	input wire [31:0] mul_src1,
	input wire [31:0] mul_src2,
	output wire mul_wr,
	output wire [31:0] mul_result,
	input wire sticky_sat_clear,
	output wire sticky_saturation_flag
);

	// ****************************************
	// Shift helpers
	// ****************************************
	// Amounts 40..63 collapse to 40; with 40-bit data that shifts every data bit out
	function [5:0] clamp_amt;
		input [5:0] amt;
		begin
			if (amt > `SFM_MAX_SHIFT) begin
				clamp_amt = `SFM_MAX_SHIFT;
			end else begin
				clamp_amt = amt;
			end
		end
	endfunction

	function [39:0] shift_right;
		input [39:0] val;
		input [5:0] amt;
		input fill;
		reg [79:0] ext;
		begin
			ext = {{40{fill}}, val} >> amt;
			shift_right = ext[39:0];
		end
	endfunction

	reg [5:0] amt;
	reg [1:0] kind;
	reg wide;
	reg sign_src;
	reg legal;
	reg [39:0] operand;
	reg [39:0] res;
	reg sat_reg;
	wire mul_sat;
	wire [5:0] eff_amt;

	localparam KIND_ASL = 2'd0;
	localparam KIND_ASR = 2'd1;
	localparam KIND_LSR = 2'd2;

	// ****************************************
	// Opcode decode
	// ****************************************
	always @* begin
		amt = {1'b0, shf_imm};
		kind = KIND_ASL;
		wide = 1'b0;
		sign_src = 1'b1;
		legal = 1'b1;
		case (shf_opcode)
		`SFM_OP_ASL_S32_REG: begin
			amt = shf_src1[5:0];
		end
		`SFM_OP_ASL_S32_IMM: begin
			amt = {1'b0, shf_imm};
		end
		`SFM_OP_ASL_S40_REG: begin
			amt = shf_src1[5:0];
			wide = 1'b1;
		end
		`SFM_OP_ASL_S40_IMM: begin
			wide = 1'b1;
		end
		`SFM_OP_ASL_U40_REG: begin
			amt = shf_src1[5:0];
			wide = 1'b1;
			sign_src = 1'b0;
		end
		`SFM_OP_ASL_U40_IMM: begin
			wide = 1'b1;
			sign_src = 1'b0;
		end
		`SFM_OP_ASR_S32_REG: begin
			amt = shf_src1[5:0];
			kind = KIND_ASR;
		end
		`SFM_OP_ASR_S32_IMM: begin
			kind = KIND_ASR;
		end
		`SFM_OP_ASR_S40_REG: begin
			amt = shf_src1[5:0];
			kind = KIND_ASR;
			wide = 1'b1;
		end
		`SFM_OP_ASR_S40_IMM: begin
			kind = KIND_ASR;
			wide = 1'b1;
		end
		`SFM_OP_LSR_U32_REG: begin
			amt = shf_src1[5:0];
			kind = KIND_LSR;
			sign_src = 1'b0;
		end
		`SFM_OP_LSR_U32_IMM: begin
			kind = KIND_LSR;
			sign_src = 1'b0;
		end
		`SFM_OP_LSR_U40_REG: begin
			amt = shf_src1[5:0];
			kind = KIND_LSR;
			wide = 1'b1;
			sign_src = 1'b0;
		end
		`SFM_OP_LSR_U40_IMM: begin
			kind = KIND_LSR;
			wide = 1'b1;
			sign_src = 1'b0;
		end
		default: begin
			legal = 1'b0;
		end
		endcase
	end

	// ****************************************
	// Operand widening
	// ****************************************
	// Unsigned left shift widens from 32 bits even with a 40-bit result
	always @* begin
		if (wide && !(kind == KIND_ASL && !sign_src)) begin
			operand = shf_src2;
		end else if (sign_src) begin
			operand = {{8{shf_src2[31]}}, shf_src2[31:0]};
		end else begin
			operand = {8'h00, shf_src2[31:0]};
		end
	end

	// Upper src1 bits ignored; issuer keeps them zero
	assign eff_amt = clamp_amt(amt);

	// ****************************************
	// Datapath
	// ****************************************
	always @* begin
		case (kind)
		KIND_ASR: begin
			res = shift_right(operand, eff_amt, operand[39]);
		end
		KIND_LSR: begin
			res = shift_right(operand, eff_amt, 1'b0);
		end
		default: begin
			res = operand << eff_amt;
		end
		endcase
		if (!wide) begin
			res = {8'h00, res[31:0]};
		end
	end

	// ****************************************
	// Shift outputs
	// ****************************************

	// Zero delay slots: result visible in the issue cycle
	always @* begin
		shf_wr = shf_valid && shf_pred && legal;
		shf_result = res;
		shf_wide = wide;
	end

	// ****************************************
	// Multiply and sticky flag
	// ****************************************
	sfm_frac_mult u_mult (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.mul_valid(mul_valid),
		.mul_pred(mul_pred),
		.mul_opcode(mul_opcode),
		.mul_src1(mul_src1),
		.mul_src2(mul_src2),
		.mul_wr_reg(mul_wr),
		.mul_result_reg(mul_result),
		.mul_sat_reg(mul_sat)
	);

	// ****************************************
	// Sticky saturation flag
	// ****************************************
	// Set beats clear in the same cycle
	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sat_reg <= 1'b0;
		end else if (mul_sat) begin
			sat_reg <= 1'b1;
		end else if (sticky_sat_clear) begin
			sat_reg <= 1'b0;
		end
	end

	assign sticky_saturation_flag = sat_reg;

endmodule
`default_nettype wire

// ===== testbench/sfm_unit_props.sv
`timescale 1ns/10ps
`default_nettype none
module sfm_unit_props (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic shf_valid,
	input wire logic shf_pred,
	input wire logic [5:0] shf_opcode,
	input wire logic [39:0] shf_src2,
	input wire logic [31:0] shf_src1,
	input wire logic shf_wr,
	input wire logic [39:0] shf_result,
	input wire logic mul_valid,
	input wire logic mul_pred,
	input wire logic [4:0] mul_opcode,
	input wire logic mul_wr,
	input wire logic [31:0] mul_result,
	input wire logic sticky_saturation_flag
);
	wire logic mgo;
	wire logic sgo;
	wire logic far;
	assign mgo = mul_valid && mul_pred && mul_opcode[2:0] == 3'h2 &&
		(mul_opcode[4:3] != 2'h3 || mul_opcode[4:3] == 2'h3);
	assign sgo = shf_valid && shf_pred;
	assign far = shf_src1[5:0] > 6'h27;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	AST_MUL_SLOT: assert property (mgo |=> mul_wr)
		else $error("multiply write late");
	AST_MUL_NOP: assert property (!mgo |=> !mul_wr)
		else $error("multiply wrote without issue");
	AST_MUL_HOLD: assert property (!mul_wr |-> $stable(mul_result))
		else $error("multiply result moved");
	AST_NO_NEG: assert property (mul_wr |-> mul_result != 32'h8000_0000)
		else $error("most negative product delivered");
	AST_FLAG: assert property ($rose(sticky_saturation_flag) |->
		$past(mul_wr) && $past(mul_result) == 32'h7fff_ffff)
		else $error("flag rose without saturation");
	AST_SHF_NOP: assert property (shf_valid && !shf_pred |-> !shf_wr)
		else $error("shift wrote with false predicate");
	AST_ASL_FAR: assert property (sgo && shf_opcode == 6'h33 && far |->
		shf_wr && shf_result == 40'h00_0000_0000)
		else $error("left shift beyond forty");
	AST_LSR_FAR: assert property (sgo && shf_opcode == 6'h27 && far |->
		shf_result == 40'h00_0000_0000)
		else $error("logical shift beyond forty");
	AST_ASR_FAR: assert property (sgo && shf_opcode == 6'h37 && far |->
		shf_result[31:0] == {32{shf_src2[31]}})
		else $error("arithmetic shift beyond forty");
	cover property (mul_wr && mul_result == 32'h7fff_ffff);
	cover property ($rose(sticky_saturation_flag));
	cover property (sgo && shf_opcode == 6'h33 && far);
endmodule
`default_nettype wire

// ===== testbench/sfm_regfile_model.sv
`timescale 1ns/10ps
`default_nettype none
module sfm_regfile_model (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic mul_wr,
	output logic [7:0] wr_count
);
	// Counts destination writes so a stretched pulse shows up
	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			wr_count <= 8'h00;
		else if (mul_wr)
			wr_count <= wr_count + 8'h01;
	end
endmodule
`default_nettype wire

// ===== testbench/sfm_unit_tb.sv
`timescale 1ns/10ps
`default_nettype none
module sfm_unit_tb;
	logic ref_clk = 0, sys_rst = 1, shf_valid = 0, shf_pred = 0;
	logic mul_valid = 0, mul_pred = 0, sticky_sat_clear = 0;
	logic [5:0] shf_opcode = 6'h00;
	logic [39:0] shf_src2 = 40'h00_0000_0000;
	logic [31:0] shf_src1 = 32'h0000_0000, mul_src1 = 32'h0000_0000;
	logic [31:0] mul_src2 = 32'h0000_0000;
	logic [4:0] shf_imm = 5'h00, mul_opcode = 5'h00;
	wire logic shf_wr, shf_wide, mul_wr, sticky_saturation_flag;
	wire logic [39:0] shf_result;
	wire logic [31:0] mul_result;
	wire logic [7:0] wr_count;
	int n_mismatch = 0, comparisons = 0, cycles = 0;
	sfm_unit dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .shf_valid(shf_valid),
		.shf_pred(shf_pred), .shf_opcode(shf_opcode), .shf_src2(shf_src2),
		.shf_src1(shf_src1), .shf_imm(shf_imm), .shf_wr(shf_wr),
		.shf_result(shf_result), .shf_wide(shf_wide), .mul_valid(mul_valid),
		.mul_pred(mul_pred), .mul_opcode(mul_opcode), .mul_src1(mul_src1),
		.mul_src2(mul_src2), .mul_wr(mul_wr), .mul_result(mul_result),
		.sticky_sat_clear(sticky_sat_clear),
		.sticky_saturation_flag(sticky_saturation_flag));
	sfm_regfile_model far_end (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.mul_wr(mul_wr), .wr_count(wr_count));
	initial forever #25 ref_clk = ~ref_clk;
	// Hang guard, well above the thirty or so cycles used
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 2000) begin
			n_mismatch++;
			conclude();
		end
	end
	task automatic check(input logic [39:0] got, input logic [39:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic shift(input logic [5:0] op, input logic [39:0] v,
		input logic [5:0] amt, input logic p, input logic [39:0] exp);
		@(posedge ref_clk);
		shf_valid <= 1;
		shf_pred <= p;
		shf_opcode <= op;
		shf_src2 <= v;
		shf_src1 <= {26'h000_0000, amt};
		shf_imm <= amt[4:0];
		@(negedge ref_clk);
		check(shf_result, exp);
		check({39'h00_0000_0000, shf_wr}, {39'h00_0000_0000, p});
	endtask
	task automatic mul(input logic [4:0] op, input logic [31:0] a,
		input logic [31:0] b, input logic [31:0] exp);
		@(posedge ref_clk);
		mul_valid <= 1;
		mul_pred <= 1;
		mul_opcode <= op;
		mul_src1 <= a;
		mul_src2 <= b;
		@(posedge ref_clk);
		mul_valid <= 0;
		@(negedge ref_clk);
		check({8'h00, mul_result}, {8'h00, exp});
	endtask
	task automatic test_shifts;
		shift(6'h33, 40'h00_4197_51a5, 6'h09, 1, 40'h00_2ea3_4a00);
		check({39'h00_0000_0000, shf_wide}, 40'h0);
		shift(6'h32, 40'h00_29e3_d31c, 6'h04, 1, 40'h00_9e3d_31c0);
		shift(6'h33, 40'h00_0000_0001, 6'h28, 1, 40'h00_0000_0000);
		shift(6'h33, 40'h00_0000_0001, 6'h3f, 1, 40'h00_0000_0000);
		shift(6'h13, 40'h00_4197_51a5, 6'h08, 1, 40'h41_9751_a500);
		check({39'h00_0000_0000, shf_wide}, 40'h1);
		shift(6'h31, 40'h09_4197_51a5, 6'h22, 1, 40'h94_0000_0000);
		shift(6'h36, 40'h00_f123_63d1, 6'h08, 1, 40'h00_fff1_2363);
		shift(6'h37, 40'h00_1492_5a41, 6'h12, 1, 40'h00_0000_0524);
		shift(6'h37, 40'h00_8000_0000, 6'h30, 1, 40'h00_ffff_ffff);
		shift(6'h35, 40'h12_1492_5a41, 6'h19, 1, 40'h00_0000_090a);
		shift(6'h27, 40'h00_ffff_ffff, 6'h28, 1, 40'h00_0000_0000);
		shift(6'h26, 40'h00_f123_63d1, 6'h08, 1, 40'h00_00f1_2363);
		shift(6'h25, 40'hff_0000_0000, 6'h08, 1, 40'h00_ff00_0000);
		shift(6'h33, 40'h00_0000_0001, 6'h01, 0, 40'h00_0000_0002);
		$display("test shifts done");
	endtask
	task automatic test_mults;
		mul(5'h1a, 32'h0000_0123, 32'h01e0_fa81, 32'hfff3_8146);
		mul(5'h0a, 32'h008a_0000, 32'h0000_00a7, 32'h0000_b40c);
		mul(5'h02, 32'h0002_0000, 32'hfffd_0000, 32'hffff_fff4);
		// The far end counts the last write one edge later
		@(negedge ref_clk);
		check({32'h0000_0000, wr_count}, 40'h00_0000_0003);
		check({39'h00_0000_0000, sticky_saturation_flag}, 40'h0);
		mul(5'h12, 32'h0000_8000, 32'h8000_0000, 32'h7fff_ffff);
		@(negedge ref_clk);
		check({39'h00_0000_0000, sticky_saturation_flag}, 40'h1);
		@(posedge ref_clk);
		mul_valid <= 1;
		mul_pred <= 0;
		sticky_sat_clear <= 1;
		@(posedge ref_clk);
		mul_valid <= 0;
		sticky_sat_clear <= 0;
		@(negedge ref_clk);
		check({39'h00_0000_0000, sticky_saturation_flag}, 40'h0);
		check({8'h00, mul_result}, 40'h00_7fff_ffff);
		check({32'h0000_0000, wr_count}, 40'h00_0000_0004);
		$display("test multiplies done");
	endtask
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge ref_clk);
		sys_rst <= 0;
		test_shifts();
		test_mults();
		conclude();
	end
endmodule
bind sfm_unit sfm_unit_props u_props (.ref_clk(ref_clk), .sys_rst(sys_rst),
	.shf_valid(shf_valid), .shf_pred(shf_pred), .shf_opcode(shf_opcode),
	.shf_src2(shf_src2), .shf_src1(shf_src1), .shf_wr(shf_wr),
	.shf_result(shf_result), .mul_valid(mul_valid), .mul_pred(mul_pred),
	.mul_opcode(mul_opcode), .mul_wr(mul_wr), .mul_result(mul_result),
	.sticky_saturation_flag(sticky_saturation_flag));
`default_nettype wire
